// *** shared/ddac_pkg.sv ***
`default_nettype none
package ddac_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] CONV_A_DATA_LOW_ADDR  = 8'hd2;
	localparam logic [7:0] CONV_A_DATA_HIGH_ADDR = 8'hd3;
	localparam logic [7:0] CONV_A_CONTROL_ADDR   = 8'hd4;
	localparam logic [7:0] CONV_B_DATA_LOW_ADDR  = 8'hd5;
	localparam logic [7:0] CONV_B_DATA_HIGH_ADDR = 8'hd6;
	localparam logic [7:0] CONV_B_CONTROL_ADDR   = 8'hd7;

	// Control register field positions
	localparam int CTL_ENABLE_BIT   = 7;
	localparam int CTL_SOURCE_HI    = 4;
	localparam int CTL_SOURCE_LO    = 3;
	localparam int CTL_JUSTIFY_HI   = 2;
	localparam int CTL_JUSTIFY_LO   = 0;
	localparam logic [7:0] CTL_WRITABLE_MASK = 8'h9f;

	// Reset values
	localparam logic [7:0]  CTL_RESET   = 8'h00;
	localparam logic [7:0]  DATA_RESET  = 8'h00;
	localparam logic [11:0] CODE_RESET  = 12'h000;

	// Update source encodings
	localparam logic [1:0] SRC_ON_DEMAND = 2'h0;
	localparam logic [1:0] SRC_TIMER3    = 2'h1;
	localparam logic [1:0] SRC_TIMER4    = 2'h2;
	localparam logic [1:0] SRC_TIMER2    = 2'h3;

	// Bus write strobe bundle
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ddac_wr_t;

	// Overflow pulses from the three timers
	typedef struct packed {
		logic t2;
		logic t3;
		logic t4;
	} ddac_ovf_t;
endpackage
`default_nettype wire

// *** hw/ddac_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddac_top
(
	input  wire logic               core_clk_i,
	input  wire logic               rst_b_i,
	input  wire ddac_pkg::ddac_wr_t sfr_wr_i,
	input  wire logic [7:0]         sfr_rd_addr_i,
	input  wire ddac_pkg::ddac_ovf_t tmr_ovf_i,
	output logic [7:0]              sfr_rdata_o,
	output logic                    sfr_rd_hit_o,
	output logic [11:0]             conv_a_code_o,
	output logic [11:0]             conv_b_code_o,
	output logic                    conv_a_enable_o,
	output logic                    conv_b_enable_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Form the 12-bit code from a byte pair under a given layout
	function automatic logic [11:0] justify_code(input logic [2:0] fmt,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [11:0] code;
		code = {hi[3:0], lo};
		if (fmt[2])
			code = {hi, lo[7:4]};
		else
			case (fmt[1:0])
				2'h1:    code = {hi[4:0], lo[7:1]};
				2'h2:    code = {hi[5:0], lo[7:2]};
				2'h3:    code = {hi[6:0], lo[7:3]};
				default: code = {hi[3:0], lo};
			endcase
		return code;
	endfunction

	// ----------------------------------------------------------------
	// Per-channel register state
	// ----------------------------------------------------------------
	logic [7:0]  ctl_r   [2];
	logic [7:0]  ctl_nxt [2];
	logic [7:0]  lo_r    [2];
	logic [7:0]  lo_nxt  [2];
	logic [7:0]  hi_r    [2];
	logic [7:0]  hi_nxt  [2];
	logic [11:0] code_r  [2];
	logic [11:0] code_nxt[2];
	logic        load    [2];
	logic [7:0]  hi_wr_val[2];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			localparam logic [7:0] A_CTL = (ch == 0) ? ddac_pkg::CONV_A_CONTROL_ADDR
			                                         : ddac_pkg::CONV_B_CONTROL_ADDR;
			localparam logic [7:0] A_LO  = (ch == 0) ? ddac_pkg::CONV_A_DATA_LOW_ADDR
			                                         : ddac_pkg::CONV_B_DATA_LOW_ADDR;
			localparam logic [7:0] A_HI  = (ch == 0) ? ddac_pkg::CONV_A_DATA_HIGH_ADDR
			                                         : ddac_pkg::CONV_B_DATA_HIGH_ADDR;
			logic       wr_ctl;
			logic       wr_lo;
			logic       wr_hi;
			logic [1:0] src;
			logic       tmr_hit;

			assign wr_ctl = sfr_wr_i.wr && (sfr_wr_i.addr == A_CTL);
			assign wr_lo  = sfr_wr_i.wr && (sfr_wr_i.addr == A_LO);
			assign wr_hi  = sfr_wr_i.wr && (sfr_wr_i.addr == A_HI);
			assign src    = ctl_r[ch][ddac_pkg::CTL_SOURCE_HI:ddac_pkg::CTL_SOURCE_LO];

			// Only the selected timer counts; others are ignored
			always_comb
			begin
				case (src)
					ddac_pkg::SRC_TIMER3: tmr_hit = tmr_ovf_i.t3;
					ddac_pkg::SRC_TIMER4: tmr_hit = tmr_ovf_i.t4;
					ddac_pkg::SRC_TIMER2: tmr_hit = tmr_ovf_i.t2;
					default:              tmr_hit = 1'b0;
				endcase
			end

			// Next state for held bytes, control and the code latch
			always_comb
			begin
				ctl_nxt[ch]   = ctl_r[ch];
				lo_nxt[ch]    = lo_r[ch];
				hi_nxt[ch]    = hi_r[ch];
				hi_wr_val[ch] = hi_r[ch];
				if (wr_ctl)
					ctl_nxt[ch] = sfr_wr_i.wdata & ddac_pkg::CTL_WRITABLE_MASK;
				if (wr_lo)
					lo_nxt[ch] = sfr_wr_i.wdata;
				if (wr_hi)
				begin
					hi_nxt[ch]    = sfr_wr_i.wdata;
					hi_wr_val[ch] = sfr_wr_i.wdata;
				end
				// On demand loads from the fresh high byte and held low byte
				if (src == ddac_pkg::SRC_ON_DEMAND)
					load[ch] = wr_hi;
				else
					load[ch] = tmr_hit;
				// Timer loads copy the pair as it stood before this edge
				if (load[ch])
					code_nxt[ch] = justify_code(
						ctl_r[ch][ddac_pkg::CTL_JUSTIFY_HI:ddac_pkg::CTL_JUSTIFY_LO],
						(src == ddac_pkg::SRC_ON_DEMAND) ? hi_wr_val[ch] : hi_r[ch],
						lo_r[ch]);
				else
					code_nxt[ch] = code_r[ch];
			end

			// State registers
			always_ff @(posedge core_clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					ctl_r[ch]  <= ddac_pkg::CTL_RESET;
					lo_r[ch]   <= ddac_pkg::DATA_RESET;
					hi_r[ch]   <= ddac_pkg::DATA_RESET;
					code_r[ch] <= ddac_pkg::CODE_RESET;
				end
				else
				begin
					ctl_r[ch]  <= ctl_nxt[ch];
					lo_r[ch]   <= lo_nxt[ch];
					hi_r[ch]   <= hi_nxt[ch];
					code_r[ch] <= code_nxt[ch];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read mux, registered so every output leaves a flip-flop
	// ----------------------------------------------------------------
	logic [7:0] rdata_nxt;
	logic       hit_nxt;

	// High reads return the held byte; low reads the last write
	always_comb
	begin
		hit_nxt = 1'b1;
		case (sfr_rd_addr_i)
			ddac_pkg::CONV_A_DATA_LOW_ADDR:  rdata_nxt = lo_r[0];
			ddac_pkg::CONV_A_DATA_HIGH_ADDR: rdata_nxt = hi_r[0];
			ddac_pkg::CONV_A_CONTROL_ADDR:   rdata_nxt = ctl_r[0];
			ddac_pkg::CONV_B_DATA_LOW_ADDR:  rdata_nxt = lo_r[1];
			ddac_pkg::CONV_B_DATA_HIGH_ADDR: rdata_nxt = hi_r[1];
			ddac_pkg::CONV_B_CONTROL_ADDR:   rdata_nxt = ctl_r[1];
			default:
			begin
				rdata_nxt = 8'h00;
				hit_nxt   = 1'b0;
			end
		endcase
	end

	// Output registers; enables drop shutdown straight from control
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sfr_rdata_o     <= 8'h00;
			sfr_rd_hit_o    <= 1'b0;
			conv_a_code_o   <= ddac_pkg::CODE_RESET;
			conv_b_code_o   <= ddac_pkg::CODE_RESET;
			conv_a_enable_o <= 1'b0;
			conv_b_enable_o <= 1'b0;
		end
		else
		begin
			sfr_rdata_o     <= rdata_nxt;
			sfr_rd_hit_o    <= hit_nxt;
			conv_a_code_o   <= code_nxt[0];
			conv_b_code_o   <= code_nxt[1];
			conv_a_enable_o <= ctl_nxt[0][ddac_pkg::CTL_ENABLE_BIT];
			conv_b_enable_o <= ctl_nxt[1][ddac_pkg::CTL_ENABLE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Decoded data strobes, kept apart from the loop so checks read plainly
	logic hi_wr_a;
	logic hi_wr_b;
	logic lo_wr_a;
	logic lo_wr_b;
	assign hi_wr_a = sfr_wr_i.wr && (sfr_wr_i.addr == ddac_pkg::CONV_A_DATA_HIGH_ADDR);
	assign hi_wr_b = sfr_wr_i.wr && (sfr_wr_i.addr == ddac_pkg::CONV_B_DATA_HIGH_ADDR);
	assign lo_wr_a = sfr_wr_i.wr && (sfr_wr_i.addr == ddac_pkg::CONV_A_DATA_LOW_ADDR);
	assign lo_wr_b = sfr_wr_i.wr && (sfr_wr_i.addr == ddac_pkg::CONV_B_DATA_LOW_ADDR);

	a_enable_follows_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		conv_a_enable_o == ctl_r[0][7])
		else $error("channel A enable mismatch");
	a_enable_follows_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		conv_b_enable_o == ctl_r[1][7])
		else $error("channel B enable mismatch");
	a_unused_bits_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		ctl_r[0][6:5] == 2'h0 && ctl_r[1][6:5] == 2'h0)
		else $error("unused control bits set");
	a_demand_hi_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_wr_i.wr && sfr_wr_i.addr == 8'hd3 && ctl_r[0][4:3] == 2'h0 && ctl_r[0][2:0] == 3'h0)
		|=> conv_a_code_o == {$past(sfr_wr_i.wdata[3:0]), lo_r[0]})
		else $error("on-demand load wrong");
	a_timer3_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == 2'h1 && tmr_ovf_i.t3 && ctl_r[0][2] && !sfr_wr_i.wr)
		|=> conv_a_code_o == {hi_r[0], lo_r[0][7:4]})
		else $error("timer 3 load wrong");
	a_timer4_only: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == 2'h2 && !tmr_ovf_i.t4) |=> $stable(conv_a_code_o))
		else $error("load without timer 4");
	a_timer2_only: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == 2'h3 && !tmr_ovf_i.t2) |=> $stable(conv_b_code_o))
		else $error("load without timer 2");
	a_low_write_held: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == 2'h0 && !(sfr_wr_i.wr && sfr_wr_i.addr == 8'hd3))
		|=> $stable(conv_a_code_o))
		else $error("latch moved without high write");
	// On-demand layouts, channel A; expected bits spelled out per layout
	a_justify1_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_a && ctl_r[0][4:0] == 5'h01) |=>
		conv_a_code_o == {$past(sfr_wr_i.wdata[4:0]), $past(lo_r[0][7:1])})
		else $error("channel A layout 001 wrong");
	a_justify2_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_a && ctl_r[0][4:0] == 5'h02) |=>
		conv_a_code_o == {$past(sfr_wr_i.wdata[5:0]), $past(lo_r[0][7:2])})
		else $error("channel A layout 010 wrong");
	a_justify3_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_a && ctl_r[0][4:0] == 5'h03) |=>
		conv_a_code_o == {$past(sfr_wr_i.wdata[6:0]), $past(lo_r[0][7:3])})
		else $error("channel A layout 011 wrong");
	a_justify4_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_a && ctl_r[0][4:3] == 2'h0 && ctl_r[0][2]) |=>
		conv_a_code_o == {$past(sfr_wr_i.wdata), $past(lo_r[0][7:4])})
		else $error("channel A layout 1xx wrong");
	// On-demand layouts, channel B
	a_demand_b_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_b && ctl_r[1][4:0] == 5'h00) |=>
		conv_b_code_o == {$past(sfr_wr_i.wdata[3:0]), $past(lo_r[1])})
		else $error("channel B on-demand load wrong");
	a_justify1_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_b && ctl_r[1][4:0] == 5'h01) |=>
		conv_b_code_o == {$past(sfr_wr_i.wdata[4:0]), $past(lo_r[1][7:1])})
		else $error("channel B layout 001 wrong");
	a_justify2_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_b && ctl_r[1][4:0] == 5'h02) |=>
		conv_b_code_o == {$past(sfr_wr_i.wdata[5:0]), $past(lo_r[1][7:2])})
		else $error("channel B layout 010 wrong");
	a_justify3_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_b && ctl_r[1][4:0] == 5'h03) |=>
		conv_b_code_o == {$past(sfr_wr_i.wdata[6:0]), $past(lo_r[1][7:3])})
		else $error("channel B layout 011 wrong");
	a_justify4_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hi_wr_b && ctl_r[1][4:3] == 2'h0 && ctl_r[1][2]) |=>
		conv_b_code_o == {$past(sfr_wr_i.wdata), $past(lo_r[1][7:4])})
		else $error("channel B layout 1xx wrong");
	// Timer loads copy the pair held before the overflow edge
	a_timer4_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == ddac_pkg::SRC_TIMER4 && tmr_ovf_i.t4 && ctl_r[0][2:0] == 3'h0) |=>
		conv_a_code_o == {$past(hi_r[0][3:0]), $past(lo_r[0])})
		else $error("channel A timer 4 load wrong");
	a_timer2_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == ddac_pkg::SRC_TIMER2 && tmr_ovf_i.t2 && ctl_r[0][2:0] == 3'h1) |=>
		conv_a_code_o == {$past(hi_r[0][4:0]), $past(lo_r[0][7:1])})
		else $error("channel A timer 2 load wrong");
	a_timer3_load_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_TIMER3 && tmr_ovf_i.t3 && ctl_r[1][2:0] == 3'h2) |=>
		conv_b_code_o == {$past(hi_r[1][5:0]), $past(lo_r[1][7:2])})
		else $error("channel B timer 3 load wrong");
	a_timer4_load_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_TIMER4 && tmr_ovf_i.t4 && ctl_r[1][2:0] == 3'h3) |=>
		conv_b_code_o == {$past(hi_r[1][6:0]), $past(lo_r[1][7:3])})
		else $error("channel B timer 4 load wrong");
	a_timer2_load_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_TIMER2 && tmr_ovf_i.t2 && ctl_r[1][2]) |=>
		conv_b_code_o == {$past(hi_r[1]), $past(lo_r[1][7:4])})
		else $error("channel B timer 2 load wrong");
	// Latch holds whenever its own source stays quiet
	a_demand_hold_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_ON_DEMAND && !hi_wr_b) |=>
		$stable(conv_b_code_o))
		else $error("channel B latch moved without high write");
	a_timer3_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == ddac_pkg::SRC_TIMER3 && !tmr_ovf_i.t3) |=>
		$stable(conv_a_code_o))
		else $error("channel A load without timer 3");
	a_timer2_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[0][4:3] == ddac_pkg::SRC_TIMER2 && !tmr_ovf_i.t2) |=>
		$stable(conv_a_code_o))
		else $error("channel A load without timer 2");
	a_timer3_only_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_TIMER3 && !tmr_ovf_i.t3) |=>
		$stable(conv_b_code_o))
		else $error("channel B load without timer 3");
	a_timer4_only_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ctl_r[1][4:3] == ddac_pkg::SRC_TIMER4 && !tmr_ovf_i.t4) |=>
		$stable(conv_b_code_o))
		else $error("channel B load without timer 4");
	// Read port returns held bytes one cycle after the address
	a_read_lo_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_rd_addr_i == ddac_pkg::CONV_A_DATA_LOW_ADDR) |=>
		(sfr_rdata_o == $past(lo_r[0]) && sfr_rd_hit_o))
		else $error("channel A low read wrong");
	a_read_hi_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_rd_addr_i == ddac_pkg::CONV_A_DATA_HIGH_ADDR) |=>
		(sfr_rdata_o == $past(hi_r[0]) && sfr_rd_hit_o))
		else $error("channel A high read wrong");
	a_read_lo_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_rd_addr_i == ddac_pkg::CONV_B_DATA_LOW_ADDR) |=>
		(sfr_rdata_o == $past(lo_r[1]) && sfr_rd_hit_o))
		else $error("channel B low read wrong");
	a_read_hi_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_rd_addr_i == ddac_pkg::CONV_B_DATA_HIGH_ADDR) |=>
		(sfr_rdata_o == $past(hi_r[1]) && sfr_rd_hit_o))
		else $error("channel B high read wrong");
	a_read_ctl_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(sfr_rd_addr_i == ddac_pkg::CONV_B_CONTROL_ADDR) |=>
		(sfr_rdata_o[6:5] == 2'h0 && sfr_rd_hit_o))
		else $error("channel B control read shows unused bits");
	// Low byte writes alone never move either latch
	a_low_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(lo_wr_a && !tmr_ovf_i.t2 && !tmr_ovf_i.t3 && !tmr_ovf_i.t4) |=>
		$stable(conv_a_code_o))
		else $error("channel A latch moved on low write");
	a_low_only_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(lo_wr_b && !tmr_ovf_i.t2 && !tmr_ovf_i.t3 && !tmr_ovf_i.t4) |=>
		$stable(conv_b_code_o))
		else $error("channel B latch moved on low write");
endmodule
`default_nettype wire

// *** dv/ddac_tmr_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// Timer overflow source model
// -----------------------------
module ddac_tmr_model
(
	input  wire logic           core_clk_i,
	input  wire logic [2:0]     fire_i,
	output var ddac_pkg::ddac_ovf_t ovf_o
);
	// Bench holds a request one cycle, so each overflow is one pulse
	always_comb
	begin
		ovf_o = ddac_pkg::ddac_ovf_t'(fire_i);
	end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                 core_clk_i = 1'b0;
	logic                 rst_b_i    = 1'b0;
	ddac_pkg::ddac_wr_t   wr         = '0;
	logic [7:0]           rd_addr    = 8'h00;
	logic [2:0]           fire       = 3'h0;
	ddac_pkg::ddac_ovf_t  ovf;
	logic [7:0]           rdata;
	logic                 hit;
	logic [11:0]          code_a;
	logic [11:0]          code_b;
	logic                 en_a;
	logic                 en_b;
	logic [7:0]           m_ctl [2];
	logic [7:0]           m_lo  [2];
	logic [7:0]           m_hi  [2];
	logic [11:0]          m_code[2];
	logic [31:0]          r;
	logic [1:0]           s;
	int                   seed = 32'ha4b1;
	int                   miscompares = 0;
	int                   samples_checked = 0;
	// -----------------------------
	// Clock, design and partner
	// -----------------------------
	always #5 core_clk_i = ~core_clk_i;
	ddac_top ddac_top_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sfr_wr_i(wr),
		.sfr_rd_addr_i(rd_addr), .tmr_ovf_i(ovf), .sfr_rdata_o(rdata), .sfr_rd_hit_o(hit),
		.conv_a_code_o(code_a), .conv_b_code_o(code_b), .conv_a_enable_o(en_a),
		.conv_b_enable_o(en_b));
	ddac_tmr_model ddac_tmr_model_inst (.core_clk_i(core_clk_i), .fire_i(fire), .ovf_o(ovf));
	// -----------------------------
	// Expectation helpers
	// -----------------------------
	function automatic logic [11:0] justify(input logic [2:0] j, input logic [7:0] h,
		input logic [7:0] l);
		if (j[2])
			return {h, l[7:4]};
		case (j[1:0])
			2'h0: return {h[3:0], l};
			2'h1: return {h[4:0], l[7:1]};
			2'h2: return {h[5:0], l[7:2]};
			default: return {h[6:0], l[7:3]};
		endcase
	endfunction
	// Places below 0xd2 read zero with no hit
	function automatic logic [8:0] rd_exp(input logic [7:0] a);
		int c;
		c = (a >= 8'hd5) ? 1 : 0;
		if (a < 8'hd2)
			return 9'h000;
		case (a - (c ? 8'hd5 : 8'hd2))
			8'h00: return {1'b1, m_lo[c]};
			8'h01: return {1'b1, m_hi[c]};
			default: return {1'b1, m_ctl[c]};
		endcase
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard: the run is far shorter than this
	initial
	begin
		#200000;
		miscompares++;
		complete_run();
	end
	// -----------------------------
	// Random traffic against a reference
	// -----------------------------
	initial
	begin
		for (int c = 0; c < 2; c++)
		begin
			m_ctl[c] = 8'h00;
			m_lo[c] = 8'h00;
			m_hi[c] = 8'h00;
			m_code[c] = 12'h000;
		end
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_b_i = 1'b1;
		chk(code_a, 12'h000);
		for (int i = 0; i < 600; i++)
		begin
			r = $random(seed);
			// Timer pulses only on idle bus cycles, so load-time control is unambiguous
			if (r[1:0] != 2'h0)
			begin
				wr.wr = 1'b1;
				wr.addr = 8'hd0 + {5'h0, r[4:2]};
				wr.wdata = r[15:8];
			end
			else
				fire = r[18:16];
			for (int c = 0; c < 2; c++)
			begin
				s = m_ctl[c][4:3];
				if (wr.wr && wr.addr == 8'hd2 + 8'(3 * c))
					m_lo[c] = wr.wdata;
				if (wr.wr && wr.addr == 8'hd4 + 8'(3 * c))
					m_ctl[c] = wr.wdata & 8'h9f;
				if (wr.wr && wr.addr == 8'hd3 + 8'(3 * c))
				begin
					m_hi[c] = wr.wdata;
					if (s == 2'h0)
						m_code[c] = justify(m_ctl[c][2:0], m_hi[c], m_lo[c]);
				end
				if ((s == 2'h1 && fire[1]) || (s == 2'h2 && fire[0]) || (s == 2'h3 && fire[2]))
					m_code[c] = justify(m_ctl[c][2:0], m_hi[c], m_lo[c]);
			end
			@(negedge core_clk_i);
			wr = '0;
			fire = 3'h0;
			rd_addr = 8'hd0 + {5'h0, r[23:21]};
			chk(code_a, m_code[0]);
			chk(code_b, m_code[1]);
			chk({11'h0, en_a}, {11'h0, m_ctl[0][7]});
			chk({11'h0, en_b}, {11'h0, m_ctl[1][7]});
			@(negedge core_clk_i);
			chk({3'h0, hit, rdata}, {3'h0, rd_exp(rd_addr)});
		end
		complete_run();
	end
endmodule
`default_nettype wire
